// file: src/hf_osc_ctrl.v
// Internal high-frequency oscillator control, calibration and suspend logic.
// Operation
// - Oscillator is system clock after reset.
// - Fixed divide-by-4 then programmable 8/4/2/1 divider.
// - Divider resets to divide-by-8.
// - Suspend bit halts oscillator and clocks; core clock is gated only on sources 000, 010 and 011.
// - Port0, port1, timer overflow, USB resume wake.
// - Wake resumes regardless of interrupt.
// - Core resumes after the suspending write.
// - Seven-bit calibration, zero fastest, ones slowest.
// - Calibration resets to trim; bit 7 zero.
// - Control bit 7 enables oscillator, resets one.
// - Ready flag reads one at programmed frequency.
// - Control bits 4:2 read zero, ignore writes.
// - Multiplier register emulated as if present.
// - Source select 000 uses divided oscillator.
`timescale 1ns/1ns
`include "hf_osc_consts.vh"
module hf_osc_ctrl #(
  parameter [6:0] CAL_TRIM = `RST_CAL_TRIM,
  parameter SETTLE = `SETTLE_CYCLES
) (
  input wire CLK_SYS,
  input wire RST,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_WE,
  input wire SFR_RE,
  input wire [2:0] SYS_CLOCK_SOURCE_SELECT,
  input wire PORT0_MATCH,
  input wire PORT1_MATCH,
  input wire THIRD_TIMER_OVF,
  input wire USB_RESUME,
  output reg [7:0] SFR_RDATA,
  output reg HF_OSC_TICK,
  output reg SYSTEM_CLOCK_TICK,
  output reg CORE_CLOCK_GATE_N,
  output reg SUSPENDED
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg hf_osc_enable_bit_r;
  reg suspend_r;
  reg [1:0] hf_post_divider_field_r;
  reg [6:0] hf_osc_calibration_r;
  reg [7:0] multiplier_control_r;
  reg hf_freq_ready_flag_r;
  reg [9:0] settle_cnt_r;
  reg [3:0] ratio;
  wire osc_tick;
  wire pre_tick;
  wire div_tick;
  wire osc_run;
  wire wake;
  wire ctl_wr = SFR_WE && SFR_ADDR == `OFS_HF_OSC_CONTROL;

  assign wake = PORT0_MATCH | PORT1_MATCH | THIRD_TIMER_OVF | USB_RESUME;
  assign osc_run = hf_osc_enable_bit_r && !suspend_r;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      hf_osc_enable_bit_r <= 1'b1;
      suspend_r <= 1'b0;
      hf_post_divider_field_r <= 2'h0;
      hf_osc_calibration_r <= CAL_TRIM;
      multiplier_control_r <= `RST_MULTIPLIER;
    end else begin
      if (ctl_wr) begin
        hf_osc_enable_bit_r <= SFR_WDATA[`BIT_ENABLE];
        hf_post_divider_field_r <= SFR_WDATA[1:0];
      end
      // A wake event in the same cycle as the suspending write keeps the part awake.
      if (wake) begin
        suspend_r <= 1'b0;
      end else if (ctl_wr && SFR_WDATA[`BIT_SUSPEND]) begin
        suspend_r <= 1'b1;
      end
      if (SFR_WE && SFR_ADDR == `OFS_HF_OSC_CALIBRATION) begin
        hf_osc_calibration_r <= SFR_WDATA[6:0];
      end
      // Only the multiplier select bits are writable; status bits stay as if locked.
      if (SFR_WE && SFR_ADDR == `OFS_MULTIPLIER_CONTROL) begin
        multiplier_control_r <= (multiplier_control_r & ~`MUL_WRITE_MASK) |
          (SFR_WDATA & `MUL_WRITE_MASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready flag
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      hf_freq_ready_flag_r <= 1'b1;
      settle_cnt_r <= 10'h000;
    end else if (!osc_run) begin
      hf_freq_ready_flag_r <= 1'b0;
      settle_cnt_r <= 10'h000;
    end else if (!hf_freq_ready_flag_r) begin
      if (settle_cnt_r >= SETTLE[9:0] - 10'h001) begin
        hf_freq_ready_flag_r <= 1'b1;
      end else begin
        settle_cnt_r <= settle_cnt_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock chain
  // ----------------------------------------------------------------
  osc_model u_osc (
    .clk(CLK_SYS),
    .rst(RST),
    .run(osc_run),
    .cal(hf_osc_calibration_r),
    .tick(osc_tick)
  );

  tick_divider #(.W(4)) u_pre (
    .clk(CLK_SYS),
    .rst(RST),
    .in_tick(osc_tick),
    .ratio(4'h4),
    .out_tick(pre_tick)
  );

  always @* begin
    case (hf_post_divider_field_r)
      2'h0: ratio = 4'h8;
      2'h1: ratio = 4'h4;
      2'h2: ratio = 4'h2;
      2'h3: ratio = 4'h1;
      default: ratio = 4'h8;
    endcase
  end

  tick_divider #(.W(4)) u_post (
    .clk(CLK_SYS),
    .rst(RST),
    .in_tick(pre_tick),
    .ratio(ratio),
    .out_tick(div_tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
      HF_OSC_TICK <= 1'b0;
      SYSTEM_CLOCK_TICK <= 1'b0;
      CORE_CLOCK_GATE_N <= 1'b1;
      SUSPENDED <= 1'b0;
    end else begin
      HF_OSC_TICK <= osc_tick;
      case (SYS_CLOCK_SOURCE_SELECT)
        `SRC_HF_SCALED: SYSTEM_CLOCK_TICK <= div_tick;
        `SRC_HF_DIV2: SYSTEM_CLOCK_TICK <= pre_tick;
        `SRC_HF_FULL: SYSTEM_CLOCK_TICK <= osc_tick;
        default: SYSTEM_CLOCK_TICK <= 1'b0;
      endcase
      // Gating holds the core on the instruction after the suspend write.
      CORE_CLOCK_GATE_N <= !(suspend_r && (SYS_CLOCK_SOURCE_SELECT == `SRC_HF_SCALED ||
        SYS_CLOCK_SOURCE_SELECT == `SRC_HF_DIV2 ||
        SYS_CLOCK_SOURCE_SELECT == `SRC_HF_FULL));
      SUSPENDED <= suspend_r;
      if (SFR_RE) begin
        case (SFR_ADDR)
          `OFS_HF_OSC_CONTROL: SFR_RDATA <= {hf_osc_enable_bit_r, hf_freq_ready_flag_r,
            suspend_r, 3'h0, hf_post_divider_field_r};
          `OFS_HF_OSC_CALIBRATION: SFR_RDATA <= {1'b0, hf_osc_calibration_r};
          `OFS_MULTIPLIER_CONTROL: SFR_RDATA <= multiplier_control_r;
          default: SFR_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // hf_osc_ctrl

// file: src/hf_osc_consts.vh
// Constants for the internal high-frequency oscillator control block.
`ifndef HF_OSC_CONSTS_VH
`define HF_OSC_CONSTS_VH
`define OFS_HF_OSC_CONTROL 8'hb2
`define OFS_HF_OSC_CALIBRATION 8'hb3
`define OFS_MULTIPLIER_CONTROL 8'hb9
`define BIT_ENABLE 7
`define BIT_READY 6
`define BIT_SUSPEND 5
`define RST_CONTROL 8'h80
`define RST_MULTIPLIER 8'he0
`define MUL_WRITE_MASK 8'h03
`define RST_CAL_TRIM 7'h40
`define FIXED_PREDIV 4
`define SETTLE_TIME_NS 400
`define CLK_PERIOD_NS 8
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SRC_HF_SCALED 3'h0
`define SRC_HF_DIV2 3'h2
`define SRC_HF_FULL 3'h3
`endif

// file: src/osc_model.v
// Behavioural oscillator tick generator with calibration-controlled period.
`timescale 1ns/1ns
module osc_model #(
  parameter BASE_PERIOD = 8
) (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [6:0] cal,
  output reg tick
);
  reg [7:0] cnt_r;
  // Period grows monotonically with the calibration code.
  wire [7:0] period = BASE_PERIOD[7:0] + {3'h0, cal[6:2]};
  always @(posedge clk) begin
    if (rst || !run) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r >= period - 8'h01) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // osc_model

// file: src/tick_divider.v
// Divides a tick stream by a run-time ratio, producing one tick per group.
`timescale 1ns/1ns
module tick_divider #(
  parameter W = 4
) (
  input wire clk,
  input wire rst,
  input wire in_tick,
  input wire [W-1:0] ratio,
  output reg out_tick
);
  reg [W-1:0] cnt_r;
  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= {W{1'b0}};
      out_tick <= 1'b0;
    end else if (in_tick && cnt_r >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_r <= {W{1'b0}};
      out_tick <= 1'b1;
    end else begin
      if (in_tick) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
      out_tick <= 1'b0;
    end
  end
endmodule // tick_divider

// file: sim/hf_osc_props.sv
// Assertion checker for the oscillator control block.
`timescale 1ns/1ns
module hf_osc_props (
  input wire CLK_SYS,
  input wire RST,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_WE,
  input wire SFR_RE,
  input wire [2:0] SYS_CLOCK_SOURCE_SELECT,
  input wire PORT0_MATCH,
  input wire PORT1_MATCH,
  input wire THIRD_TIMER_OVF,
  input wire USB_RESUME,
  input wire [7:0] SFR_RDATA,
  input wire HF_OSC_TICK,
  input wire CORE_CLOCK_GATE_N,
  input wire SUSPENDED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire wake = PORT0_MATCH | PORT1_MATCH | THIRD_TIMER_OVF | USB_RESUME;
  wire ctl_rd = SFR_RE && SFR_ADDR == 8'hb2;
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  sequence s_susp_wr; SFR_WE && SFR_ADDR == 8'hb2 && SFR_WDATA[5] && !wake; endsequence
  sequence s_rouse; SUSPENDED && wake; endsequence
  property p_rst; $fell(RST) |-> CORE_CLOCK_GATE_N && !SUSPENDED; endproperty
  // The suspend bit and its gate are registered once more at the pins, hence two cycles.
  property p_susp; s_susp_wr |-> ##2 SUSPENDED; endproperty
  property p_gate;
    s_susp_wr ##0 SYS_CLOCK_SOURCE_SELECT == 3'h0 |-> ##2 !CORE_CLOCK_GATE_N;
  endproperty
  property p_wake; s_rouse |-> ##2 !SUSPENDED; endproperty
  property p_resume; s_rouse |-> ##[1:2] CORE_CLOCK_GATE_N; endproperty
  property p_halt; SUSPENDED [*3] |-> !HF_OSC_TICK; endproperty
  property p_rsv; ctl_rd |=> SFR_RDATA[5:2] == {SUSPENDED, 3'h0}; endproperty
  property p_rdy; ctl_rd && SUSPENDED |=> !SFR_RDATA[6]; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_susp: assert property (p_susp) else $error("suspend not entered");
  a_gate: assert property (p_gate) else $error("core clock not stopped");
  a_wake: assert property (p_wake) else $error("wake event ignored");
  a_resume: assert property (p_resume) else $error("core clock not back");
  a_halt: assert property (p_halt) else $error("oscillator ticks in suspend");
  a_rsv: assert property (p_rsv) else $error("control read bits wrong");
  a_rdy: assert property (p_rdy) else $error("ready set in suspend");
endmodule // hf_osc_props
bind hf_osc_ctrl hf_osc_props u_hf_osc_props (.CLK_SYS(CLK_SYS), .RST(RST), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .PORT0_MATCH(PORT0_MATCH),
  .SYS_CLOCK_SOURCE_SELECT(SYS_CLOCK_SOURCE_SELECT), .PORT1_MATCH(PORT1_MATCH),
  .THIRD_TIMER_OVF(THIRD_TIMER_OVF), .USB_RESUME(USB_RESUME), .SFR_RDATA(SFR_RDATA),
  .HF_OSC_TICK(HF_OSC_TICK), .CORE_CLOCK_GATE_N(CORE_CLOCK_GATE_N), .SUSPENDED(SUSPENDED));

// file: sim/tb.sv
// Register-level testbench for the oscillator control block.
`timescale 1ns/1ns
module tb;
  reg CLK_SYS = 1'b0;
  reg RST = 1'b1;
  reg [7:0] SFR_ADDR = 8'h00;
  reg [7:0] SFR_WDATA = 8'h00;
  reg SFR_WE = 1'b0;
  reg SFR_RE = 1'b0;
  reg [3:0] wk = 4'h0;
  reg [2:0] src = 3'h0;
  wire [7:0] SFR_RDATA;
  wire HF_OSC_TICK, SYSTEM_CLOCK_TICK, CORE_CLOCK_GATE_N, SUSPENDED;
  int n_mismatch = 0, tests_run = 0, cyc = 0, i;
  reg [7:0] m, n;
  always #4 CLK_SYS = ~CLK_SYS;
  // Short settle count keeps the restart waits brief.
  hf_osc_ctrl #(.SETTLE(2)) u_hf_osc_ctrl (.CLK_SYS(CLK_SYS), .RST(RST), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SYS_CLOCK_SOURCE_SELECT(src),
    .PORT0_MATCH(wk[0]), .PORT1_MATCH(wk[1]), .THIRD_TIMER_OVF(wk[2]), .USB_RESUME(wk[3]),
    .SFR_RDATA(SFR_RDATA), .HF_OSC_TICK(HF_OSC_TICK), .SYSTEM_CLOCK_TICK(SYSTEM_CLOCK_TICK),
    .CORE_CLOCK_GATE_N(CORE_CLOCK_GATE_N), .SUSPENDED(SUSPENDED));
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task chk(input [7:0] g, input [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge CLK_SYS); SFR_ADDR = a; SFR_WDATA = d; SFR_WE = 1'b1;
    @(negedge CLK_SYS); SFR_WE = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge CLK_SYS); SFR_ADDR = a; SFR_RE = 1'b1;
    @(negedge CLK_SYS); SFR_RE = 1'b0;
    chk(SFR_RDATA, e);
  endtask
  // Oscillator ticks between two system ticks, then cycles between oscillator ticks.
  task gap(output [7:0] c);
    c = 8'h00;
    @(posedge CLK_SYS iff SYSTEM_CLOCK_TICK);
    do begin @(posedge CLK_SYS); c = c + {7'h0, HF_OSC_TICK}; end while (!SYSTEM_CLOCK_TICK);
  endtask
  task hp(output [7:0] c);
    c = 8'h00;
    @(posedge CLK_SYS iff HF_OSC_TICK);
    do begin @(posedge CLK_SYS); c = c + 8'h01; end while (!HF_OSC_TICK);
  endtask
  task conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude;
    end
  end
  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    repeat (2) @(negedge CLK_SYS);
    RST = 1'b0;
    rd(8'hb2, 8'hc0);
    rd(8'hb3, 8'h40);
    rd(8'hb9, 8'he0);
    rd(8'h55, 8'h00);
    wr(8'hb9, 8'hff); rd(8'hb9, 8'he3);
    wr(8'hb2, 8'h9c); rd(8'hb2, 8'hc0);
    gap(n); chk(n, 8'd32);
    wr(8'hb3, 8'h80); hp(m); hp(m); rd(8'hb3, 8'h00);
    wr(8'hb3, 8'hff); hp(n); hp(n); rd(8'hb3, 8'h7f);
    chk({7'h0, m < n}, 8'h01);
    wr(8'hb3, 8'h40);
    for (i = 0; i < 4; i++) begin
      wr(8'hb2, 8'h80 | i[7:0]); gap(n); gap(n);
      chk(n, 8'd32 >> i);
    end
    // Each wake source in turn; the suspend read doubles as a ready check.
    for (i = 0; i < 4; i++) begin
      wr(8'hb2, 8'ha0); @(negedge CLK_SYS);
      chk({6'h0, SUSPENDED, CORE_CLOCK_GATE_N}, 8'h02);
      rd(8'hb2, 8'ha0);
      @(negedge CLK_SYS); wk = 4'h1 << i;
      @(negedge CLK_SYS); wk = 4'h0;
      repeat (2) @(negedge CLK_SYS);
      chk({6'h0, SUSPENDED, CORE_CLOCK_GATE_N}, 8'h01);
      repeat (60) @(negedge CLK_SYS); rd(8'hb2, 8'hc0);
    end
    // A wake event in the same cycle as the suspending write keeps the part running.
    wk = 4'h8; wr(8'hb2, 8'ha0); wk = 4'h0; @(negedge CLK_SYS);
    chk({6'h0, SUSPENDED, CORE_CLOCK_GATE_N}, 8'h01);
    src = 3'h3; gap(n); gap(n); chk(n, 8'h01);
    src = 3'h2; gap(n); gap(n); chk(n, 8'h04);
    // An external source keeps the core clocked while the oscillator is suspended.
    src = 3'h1; wr(8'hb2, 8'ha0); @(negedge CLK_SYS);
    chk({6'h0, SUSPENDED, CORE_CLOCK_GATE_N}, 8'h03);
    wk = 4'h4; @(negedge CLK_SYS); wk = 4'h0; src = 3'h0;
    repeat (2) @(negedge CLK_SYS);
    chk({6'h0, SUSPENDED, CORE_CLOCK_GATE_N}, 8'h01);
    wr(8'hb2, 8'h00); rd(8'hb2, 8'h00);
    n = 8'h00;
    repeat (60) begin @(posedge CLK_SYS); n = n + {7'h0, HF_OSC_TICK}; end
    chk(n, 8'h00);
    wr(8'hb2, 8'h80); repeat (60) @(negedge CLK_SYS); rd(8'hb2, 8'hc0);
    conclude;
  end
endmodule // tb
